// ===== src/microstep_chopper_control.sv
/*
  Step/direction sequencer and fixed mixed-decay PWM chopper of a
  bipolar stepping motor driver, with an AXI4-Lite register slave.
  Assumes all pins synchronous to clk; the current comparators, the
  DAC taking the phase levels and the power bridges are outside.
*/
`timescale 1ns/1ps

//
// Operation
// - all mode pins equal means standby
// - standby stops logic, monitor released
// - ignore steps about 200 us after standby
// - enable high drives bridges, low releases
// - reset low holds initial position
// - reset low resets position even disabled
// - step clockwise on low direction, else counter
// - standby overrides output enable
// - initial currents per excitation mode
// - positive means first output to second
// - charge ends when current reaches level
// - subcycle is master/20, period master/100
// - chopping period is five subcycles
// - fast decay in last two subcycles
// - over level at sense ends charge after sense window
// - brief charge at every sense point
// - switch sets for positive current
// - switch sets for negative current
// - dead time on every switch change
// - decode the six excitation modes
// - mode change restarts from initial position
// - monitor low at initial position
module microstep_chopper_control
  import microstep_pkg::*;
#(
  parameter int unsigned WAKE_CYCLES = WAKE_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mode_select_first,
  input wire logic mode_select_second,
  input wire logic mode_select_third,
  input wire logic output_enable,
  input wire logic position_reset_b,
  input wire logic step_clock,
  input wire logic rotation_direction,
  input wire logic current_trip_a,
  input wire logic current_trip_b,
  output logic angle_monitor_out_o,
  output logic angle_monitor_out_oe,
  output bridge_gate_t bridge_a_gates,
  output bridge_gate_t bridge_b_gates,
  output logic bridge_a_drive,
  output logic bridge_b_drive,
  output phase_level_t phase_a_level,
  output phase_level_t phase_b_level,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_chk
    $error("WAKE_CYCLES must lie in 1..65535");
  end

  function automatic step_mode_t decode_mode(input logic [2:0] c);
    case (c)
      3'h1: decode_mode = MODE_FULL;
      3'h2: decode_mode = MODE_HALF_A;
      3'h3: decode_mode = MODE_HALF_B;
      3'h4: decode_mode = MODE_QUARTER;
      3'h5: decode_mode = MODE_EIGHTH;
      3'h6: decode_mode = MODE_SIXTEENTH;
      default: decode_mode = MODE_STANDBY;
    endcase
  endfunction

  function automatic logic [5:0] step_of(input step_mode_t m);
    case (m)
      MODE_FULL: step_of = 6'h10;
      MODE_HALF_A, MODE_HALF_B: step_of = 6'h08;
      MODE_QUARTER: step_of = 6'h04;
      MODE_EIGHTH: step_of = 6'h02;
      MODE_SIXTEENTH: step_of = 6'h01;
      default: step_of = 6'h00;
    endcase
  endfunction

  function automatic logic [5:0] init_of(input step_mode_t m);
    init_of = (m == MODE_FULL) ? POS_INIT_FULL : POS_INIT;
  endfunction

  // phase a follows cosine, phase b sine of the electrical angle
  function automatic phase_level_t phase_of(input logic [5:0] pos,
                                            input step_mode_t m,
                                            input logic is_b);
    logic [1:0] q;
    logic [3:0] k;
    logic [4:0] ki;
    logic use_co;
    phase_level_t lv;
    q = pos[5:4];
    k = pos[3:0];
    use_co = q[0] ~^ is_b;
    ki = use_co ? 5'h10 - {1'b0, k} : {1'b0, k};
    lv.mag = LEVEL_TAB[ki];
    if (k == 4'h8 && (m == MODE_FULL || m == MODE_HALF_B)) begin
      lv.mag = LEVEL_FULL;
    end
    lv.neg = is_b ? q[1] : (q[1] ^ q[0]);
    phase_of = lv;
  endfunction

  // ---- step position
  logic [2:0] code_now;
  logic [2:0] code_r, code_nxt;
  logic standby_now;
  logic standby_r, standby_nxt;
  logic [15:0] wake_r, wake_nxt;
  logic step_prev_r, step_prev_nxt;
  logic [5:0] pos_r, pos_nxt;
  phase_level_t lvl_a_r, lvl_a_nxt, lvl_b_r, lvl_b_nxt;
  logic mon_oe_r, mon_oe_nxt;
  logic drive_r, drive_nxt;
  step_mode_t mode_now;
  step_mode_t mode_r;
  logic accept;

  assign code_now = {mode_select_first, mode_select_second, mode_select_third};
  assign mode_r = decode_mode(code_r);

  always_comb begin
    standby_now = (code_now == 3'h0) || (code_now == 3'h7);
    mode_now = decode_mode(code_now);
    accept = step_clock && !step_prev_r && !standby_now && wake_r == 16'h0000
             && position_reset_b && output_enable;
    code_nxt = code_now;
    standby_nxt = standby_now;
    step_prev_nxt = step_clock;
    pos_nxt = pos_r;
    if (code_now != code_r || !position_reset_b) begin
      pos_nxt = init_of(mode_now);
    end else if (accept) begin
      pos_nxt = rotation_direction ? pos_r - step_of(mode_now)
                                   : pos_r + step_of(mode_now);
    end
    wake_nxt = wake_r;
    if (standby_r && !standby_now) begin
      wake_nxt = 16'(WAKE_CYCLES);
    end else if (wake_r != 16'h0000) begin
      wake_nxt = wake_r - 16'h0001;
    end
    lvl_a_nxt = phase_of(pos_r, mode_r, 1'b0);
    lvl_b_nxt = phase_of(pos_r, mode_r, 1'b1);
    mon_oe_nxt = !standby_now && pos_nxt == init_of(mode_now);
    drive_nxt = !standby_now && output_enable;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      code_r <= 3'h0;
      standby_r <= 1'b1;
      wake_r <= 16'h0000;
      step_prev_r <= 1'b0;
      pos_r <= POS_INIT;
      lvl_a_r <= '0;
      lvl_b_r <= '0;
      mon_oe_r <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      standby_r <= standby_nxt;
      wake_r <= wake_nxt;
      step_prev_r <= step_prev_nxt;
      pos_r <= pos_nxt;
      lvl_a_r <= lvl_a_nxt;
      lvl_b_r <= lvl_b_nxt;
      mon_oe_r <= mon_oe_nxt;
      drive_r <= drive_nxt;
    end
  end

  assign angle_monitor_out_o = 1'b0;
  assign angle_monitor_out_oe = mon_oe_r;
  assign phase_a_level = lvl_a_r;
  assign phase_b_level = lvl_b_r;
  assign bridge_a_drive = drive_r;
  assign bridge_b_drive = drive_r;

  // ---- master clock and chopper timing
  logic [7:0] mclk_div_r, mclk_div_nxt;
  logic [7:0] div_r, div_nxt;
  logic [4:0] mcnt_r, mcnt_nxt;
  logic [2:0] sub_r, sub_nxt;
  logic tick;
  logic chop_start;
  logic in_sense;

  always_comb begin
    tick = div_r >= mclk_div_r;
    chop_start = tick && mcnt_r == SUB_LAST && sub_r == CHOP_LAST;
    in_sense = sub_r == 3'h0 && mcnt_r < SENSE_TICKS;
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
    mcnt_nxt = mcnt_r;
    sub_nxt = sub_r;
    if (!drive_r) begin
      div_nxt = 8'h00;
      mcnt_nxt = 5'h00;
      sub_nxt = 3'h0;
    end else if (tick) begin
      if (mcnt_r == SUB_LAST) begin
        mcnt_nxt = 5'h00;
        sub_nxt = (sub_r == CHOP_LAST) ? 3'h0 : sub_r + 3'h1;
      end else begin
        mcnt_nxt = mcnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 8'h00;
      mcnt_r <= 5'h00;
      sub_r <= 3'h0;
    end else begin
      div_r <= div_nxt;
      mcnt_r <= mcnt_nxt;
      sub_r <= sub_nxt;
    end
  end

  // ---- per-bridge decay sequencer and dead time
  logic [1:0] trip;
  phase_level_t lvl [2];
  decay_t decay_r [2];
  bridge_gate_t sw_r [2];

  assign trip = {current_trip_b, current_trip_a};
  assign lvl[0] = lvl_a_r;
  assign lvl[1] = lvl_b_r;
  assign bridge_a_gates = sw_r[0];
  assign bridge_b_gates = sw_r[1];

  for (genvar i = 0; i < 2; i++) begin : g_bridge
    decay_t decay_nxt;
    bridge_gate_t tgt;
    bridge_gate_t sw_nxt;
    logic [6:0] dcnt_r, dcnt_nxt;

    always_comb begin
      decay_nxt = decay_r[i];
      if (!drive_r) begin
        decay_nxt = DECAY_SLOW;
      end else if (chop_start) begin
        decay_nxt = DECAY_CHARGE;
      end else begin
        case (decay_r[i])
          DECAY_CHARGE: begin
            if (!in_sense && (trip[i] || lvl[i].mag == 10'h000)) begin
              decay_nxt = (sub_r >= FAST_FIRST) ? DECAY_FAST : DECAY_SLOW;
            end
          end
          DECAY_SLOW: begin
            if (sub_r >= FAST_FIRST) begin
              decay_nxt = DECAY_FAST;
            end
          end
          DECAY_FAST: decay_nxt = DECAY_FAST;
          default: decay_nxt = DECAY_SLOW;
        endcase
      end
      case (decay_r[i])
        DECAY_CHARGE: tgt = lvl[i].neg ? GATE_TWO_ONE : GATE_ONE_TWO;
        DECAY_FAST: tgt = lvl[i].neg ? GATE_ONE_TWO : GATE_TWO_ONE;
        default: tgt = GATE_LOWS;
      endcase
      sw_nxt = sw_r[i];
      dcnt_nxt = 7'h00;
      if (!drive_r) begin
        sw_nxt = GATE_OFF;
      end else if (sw_r[i] != tgt) begin
        // every switch-off restarts the dead time before anything turns on
        if ((sw_r[i] & tgt) != sw_r[i]) begin
          sw_nxt = sw_r[i] & tgt;
          dcnt_nxt = 7'h01;
        end else if (dcnt_r > DEAD_LAST) begin
          sw_nxt = tgt;
        end else begin
          dcnt_nxt = dcnt_r + 7'h01;
        end
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        decay_r[i] <= DECAY_SLOW;
        sw_r[i] <= GATE_OFF;
        dcnt_r <= 7'h00;
      end else begin
        decay_r[i] <= decay_nxt;
        sw_r[i] <= sw_nxt;
        dcnt_r <= dcnt_nxt;
      end
    end
  end

  // ---- AXI4-Lite slave
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    mclk_div_nxt = mclk_div_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_full_r && w_full_r) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (awaddr_r == ADDR_CTRL) begin
        if (wstrb_r[0]) begin
          mclk_div_nxt = wdata_r[CTRL_DIV_LSB +: 8];
        end
      end else if (awaddr_r != ADDR_STATUS && awaddr_r != ADDR_LEVEL) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_nxt[CTRL_DIV_LSB +: 8] = mclk_div_r;
        ADDR_STATUS: begin
          rdata_nxt[ST_POS_LSB +: 6] = pos_r;
          rdata_nxt[ST_STBY_BIT] = standby_r;
          rdata_nxt[ST_WAKE_BIT] = wake_r != 16'h0000;
          rdata_nxt[ST_DRIVE_BIT] = drive_r;
          rdata_nxt[ST_MODE_LSB +: 3] = code_r;
        end
        ADDR_LEVEL: begin
          rdata_nxt[LV_A_LSB +: 11] = lvl_a_r;
          rdata_nxt[LV_B_LSB +: 11] = lvl_b_r;
        end
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      mclk_div_r <= CTRL_DIV_RST;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      mclk_div_r <= mclk_div_nxt;
    end
  end

endmodule

// ===== src/microstep_pkg.sv
/*
  Shared constants and types of the microstep chopper controller:
  timing counts, register map, current table and carrier types.
  Assumes a 250 MHz system clock.
*/
package microstep_pkg;
  localparam int CLK_FREQ_MHZ = 250;
  localparam int WAKE_TIME_US = 200;
  localparam int WAKE_CYCLES_DEF = WAKE_TIME_US * CLK_FREQ_MHZ;
  localparam int DEAD_TIME_NS = 300;
  localparam int DEAD_CYCLES = (DEAD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [6:0] DEAD_LAST = 7'(DEAD_CYCLES - 1);

  localparam int SUB_DIV = 20;
  localparam int CHOP_DIV = 100;
  localparam logic [4:0] SUB_LAST = 5'(SUB_DIV - 1);
  localparam logic [2:0] CHOP_LAST = 3'(CHOP_DIV / SUB_DIV - 1);
  localparam logic [2:0] FAST_FIRST = 3'h3;
  localparam logic [4:0] SENSE_TICKS = 5'h01;

  localparam logic [5:0] POS_INIT = 6'h00;
  localparam logic [5:0] POS_INIT_FULL = 6'h38;

  localparam int AXI_AW = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LEVEL = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_DIV_LSB = 0;
  localparam logic [7:0] CTRL_DIV_RST = 8'h3F;
  localparam int ST_POS_LSB = 0;
  localparam int ST_STBY_BIT = 8;
  localparam int ST_WAKE_BIT = 9;
  localparam int ST_DRIVE_BIT = 10;
  localparam int ST_MODE_LSB = 12;
  localparam int LV_A_LSB = 0;
  localparam int LV_B_LSB = 16;

  localparam logic [9:0] LEVEL_FULL = 10'h3E8;
  localparam logic [9:0] LEVEL_TAB [17] = '{
    10'h000, 10'h062, 10'h0C3, 10'h122, 10'h17F, 10'h1D7, 10'h22C,
    10'h27A, 10'h2C3, 10'h305, 10'h33F, 10'h372, 10'h39C, 10'h3BD,
    10'h3D5, 10'h3E3, 10'h3E8};

  typedef enum logic [2:0] {
    MODE_STANDBY, MODE_FULL, MODE_HALF_A, MODE_HALF_B,
    MODE_QUARTER, MODE_EIGHTH, MODE_SIXTEENTH
  } step_mode_t;

  typedef enum logic [1:0] {DECAY_CHARGE, DECAY_SLOW, DECAY_FAST} decay_t;

  typedef struct packed {
    logic high_side_one;
    logic high_side_two;
    logic low_side_one;
    logic low_side_two;
  } bridge_gate_t;

  typedef struct packed {
    logic neg;
    logic [9:0] mag;
  } phase_level_t;

  localparam bridge_gate_t GATE_OFF = 4'h0;
  localparam bridge_gate_t GATE_ONE_TWO = 4'h9;
  localparam bridge_gate_t GATE_LOWS = 4'h3;
  localparam bridge_gate_t GATE_TWO_ONE = 4'h6;
endpackage

// ===== tb/winding_model.sv
/*
  Motor winding seen through the current comparator of one bridge.
  Assumes the bridge gates and commanded level of the chopper controller.
*/
`timescale 1ns/1ps
module winding_model
  import microstep_pkg::*;
#(
  parameter int CHARGE_LEN = 40
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire bridge_gate_t gates,
  input wire phase_level_t level,
  output logic trip
);
  logic [7:0] rise_r;
  logic [7:0] rise_nxt;
  logic charging;

  // current builds only while the bridge pushes it the commanded way
  assign charging = level.neg ? (gates == GATE_TWO_ONE) : (gates == GATE_ONE_TWO);

  always_comb begin
    rise_nxt = 8'h00;
    if (charging && rise_r != 8'hFF) begin
      rise_nxt = rise_r + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_r <= 8'h00;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  assign trip = charging && (rise_r >= 8'(CHARGE_LEN));
endmodule

// ===== tb/microstep_chopper_control_properties.sv
/*
  Pin-level checker of the chopper controller: standby, enable, dead time,
  bridge safety and initial phase a level. Bound to the top module by name.
*/
`timescale 1ns/1ps
module microstep_chopper_control_properties
  import microstep_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mode_select_first,
  input wire logic mode_select_second,
  input wire logic mode_select_third,
  input wire logic output_enable,
  input wire logic angle_monitor_out_oe,
  input wire bridge_gate_t bridge_a_gates,
  input wire bridge_gate_t bridge_b_gates,
  input wire logic bridge_a_drive,
  input wire logic bridge_b_drive,
  input wire phase_level_t phase_a_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic stby;
  logic [6:0] hold_a_r;
  logic [6:0] hold_b_r;
  bridge_gate_t last_a_r;
  bridge_gate_t last_b_r;

  assign stby = (mode_select_first == mode_select_second) &&
                (mode_select_second == mode_select_third);

  // cycles for which each gate set has stood unchanged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_a_r <= 7'h7F;
      hold_b_r <= 7'h7F;
      last_a_r <= GATE_OFF;
      last_b_r <= GATE_OFF;
    end else begin
      hold_a_r <= (bridge_a_gates != last_a_r) ? 7'h00 : hold_a_r + 7'(hold_a_r != 7'h7F);
      hold_b_r <= (bridge_b_gates != last_b_r) ? 7'h00 : hold_b_r + 7'(hold_b_r != 7'h7F);
      last_a_r <= bridge_a_gates;
      last_b_r <= bridge_b_gates;
    end
  end

  a_standby_monitor_off: assert property (stby [*3] |-> !angle_monitor_out_oe)
    else $error("monitor pulled low in standby");
  a_standby_beats_enable: assert property (stby [*3] |-> !bridge_a_drive && !bridge_b_drive)
    else $error("bridges driven in standby");
  a_disable_drive_off: assert property (!output_enable [*3] |-> !bridge_a_drive && !bridge_b_drive)
    else $error("bridges driven while disabled");
  a_idle_gates_off: assert property (!bridge_a_drive [*2] |-> bridge_a_gates == GATE_OFF)
    else $error("gates on while bridge released");
  a_dead_time_a: assert property (|(bridge_a_gates & ~last_a_r) |-> hold_a_r >= DEAD_LAST)
    else $error("bridge a switch on without dead time");
  a_dead_time_b: assert property (|(bridge_b_gates & ~last_b_r) |-> hold_b_r >= DEAD_LAST)
    else $error("bridge b switch on without dead time");
  a_no_shoot_a: assert property (!(bridge_a_gates.high_side_one && bridge_a_gates.low_side_one) &&
    !(bridge_a_gates.high_side_two && bridge_a_gates.low_side_two))
    else $error("bridge a leg shorted");
  a_no_shoot_b: assert property (!(bridge_b_gates.high_side_one && bridge_b_gates.low_side_one) &&
    !(bridge_b_gates.high_side_two && bridge_b_gates.low_side_two))
    else $error("bridge b leg shorted");
  a_initial_a_level: assert property (angle_monitor_out_oe [*3] |->
    phase_a_level == {1'b0, LEVEL_FULL})
    else $error("phase a not full at initial position");

  c_initial: cover property (angle_monitor_out_oe);
  c_pos_charge: cover property (bridge_a_gates == GATE_ONE_TWO);
  c_neg_charge: cover property (bridge_b_gates == GATE_TWO_ONE);
endmodule

bind microstep_chopper_control microstep_chopper_control_properties i_props (
  .clk, .rst_b, .mode_select_first, .mode_select_second, .mode_select_third,
  .output_enable, .angle_monitor_out_oe, .bridge_a_gates, .bridge_b_gates,
  .bridge_a_drive, .bridge_b_drive, .phase_a_level
);

// ===== tb/microstep_chopper_control_tb.sv
/*
  Self-checking bench of the chopper controller: registers, standby,
  modes, stepping, enable and reset, and chopper timing.
  Assumes the winding models answer the current comparators.
*/
`timescale 1ns/1ps
module microstep_chopper_control_tb;
  import microstep_pkg::*;
  localparam int WAKE = 20;
  localparam int DIV = 7;
  localparam int SUB = SUB_DIV * (DIV + 1);
  logic clk, rst_b, mode_select_first, mode_select_second, mode_select_third;
  logic output_enable, position_reset_b, step_clock, rotation_direction;
  logic current_trip_a, current_trip_b, angle_monitor_out_o, angle_monitor_out_oe;
  logic bridge_a_drive, bridge_b_drive, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  bridge_gate_t bridge_a_gates, bridge_b_gates;
  phase_level_t phase_a_level, phase_b_level;
  int miscompares, cmp_count, cycles;

  microstep_chopper_control #(.WAKE_CYCLES(WAKE)) i_dut (.clk, .rst_b, .mode_select_first,
    .mode_select_second, .mode_select_third, .output_enable, .position_reset_b, .step_clock,
    .rotation_direction, .current_trip_a, .current_trip_b, .angle_monitor_out_o,
    .angle_monitor_out_oe, .bridge_a_gates, .bridge_b_gates, .bridge_a_drive, .bridge_b_drive,
    .phase_a_level, .phase_b_level, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  winding_model i_wind_a (.clk, .rst_b, .gates(bridge_a_gates), .level(phase_a_level),
    .trip(current_trip_a));
  winding_model i_wind_b (.clk, .rst_b, .gates(bridge_b_gates), .level(phase_b_level),
    .trip(current_trip_b));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [3:0] a);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic set_mode(input logic [2:0] code);
    @(posedge clk);
    {mode_select_first, mode_select_second, mode_select_third} <= code;
    tick(3);
  endtask

  task automatic step(input logic dir);
    @(posedge clk);
    rotation_direction <= dir;
    @(posedge clk);
    step_clock <= 1'b1;
    tick(2);
    step_clock <= 1'b0;
    tick(2);
  endtask

  task automatic pos_is(input logic [5:0] exp);
    axi_rd(ADDR_STATUS);
    chk("position", {26'h0, exp}, {26'h0, v[5:0]});
  endtask

  task automatic t_regs();
    axi_rd(ADDR_CTRL);
    chk("ctrl reset", {24'h0, CTRL_DIV_RST}, v);
    axi_rd(4'hC);
    chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(4'hC, 32'h0000_0001);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(ADDR_CTRL, DIV);
    chk("ctrl write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    axi_rd(ADDR_CTRL);
    chk("ctrl readback", DIV, v);
    axi_rd(ADDR_LEVEL);
    chk("level register", {21'h0, 1'b0, LEVEL_FULL}, v);
  endtask

  task automatic t_standby();
    for (int i = 0; i < 2; i++) begin
      set_mode(i ? 3'h7 : 3'h0);
      axi_rd(ADDR_STATUS);
      chk("standby flag", 1, v[ST_STBY_BIT]);
      chk("monitor in standby", 0, angle_monitor_out_oe);
      chk("drive in standby", 0, bridge_a_drive);
    end
    set_mode(3'h1);
    step(1'b0);
    axi_rd(ADDR_STATUS);
    chk("wake blank flag", 1, v[ST_WAKE_BIT]);
    tick(WAKE + 5);
    pos_is(POS_INIT_FULL);
    step(1'b0);
    pos_is(6'h08);
  endtask

  task automatic t_modes();
    int sz [7] = '{0, 16, 8, 8, 4, 2, 1};
    for (int c = 6; c >= 1; c--) begin
      set_mode(3'(c));
      axi_rd(ADDR_STATUS);
      chk("mode code", c, v[14:12]);
      chk("initial position", c == 1 ? POS_INIT_FULL : POS_INIT, v[5:0]);
      chk("monitor at initial", 1, angle_monitor_out_oe);
      chk("monitor data", 0, angle_monitor_out_o);
      chk("phase a initial", {1'b0, LEVEL_FULL}, phase_a_level);
      chk("phase b initial", c == 1 ? {1'b1, LEVEL_FULL} : 11'h0, phase_b_level);
      step(1'b0);
      pos_is(6'((c == 1 ? POS_INIT_FULL : POS_INIT) + sz[c]));
      chk("monitor after step", 0, angle_monitor_out_oe);
    end
  endtask

  task automatic t_dir_reset();
    set_mode(3'h6);
    step(1'b1);
    pos_is(6'h3F);
    step(1'b0);
    pos_is(6'h00);
    step(1'b0);
    pos_is(6'h01);
    position_reset_b <= 1'b0;
    step(1'b0);
    pos_is(6'h00);
    position_reset_b <= 1'b1;
    step(1'b0);
    output_enable <= 1'b0;
    step(1'b0);
    pos_is(6'h01);
    chk("drive when disabled", 0, bridge_a_drive);
    chk("drive b when disabled", 0, bridge_b_drive);
    chk("gates when disabled", GATE_OFF, bridge_b_gates);
    position_reset_b <= 1'b0;
    tick(3);
    pos_is(6'h00);
    output_enable <= 1'b1;
    tick(3);
    chk("drive when enabled", 1, bridge_a_drive);
    position_reset_b <= 1'b1;
    step(1'b0);
    pos_is(6'h01);
  endtask

  task automatic t_chop(input logic use_b, input bridge_gate_t chg, input bridge_gate_t fst);
    int first, second, fast;
    bridge_gate_t g, prev;
    first = -1;
    second = -1;
    fast = 0;
    prev = chg;
    for (int t = 0; t < 5000 && second < 0; t++) begin
      @(posedge clk);
      g = use_b ? bridge_b_gates : bridge_a_gates;
      if (g == chg && prev != chg) begin
        if (first < 0) first = t;
        else second = t;
      end
      if (first >= 0 && second < 0 && g == fst) fast++;
      prev = g;
    end
    chk("chop period", CHOP_DIV * (DIV + 1), second - first);
    // one cycle goes to registering the decay state before the gates follow
    chk("fast share", 2 * SUB - DEAD_CYCLES - 1, fast);
  endtask

  initial begin
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    rst_b = 1'b0;
    {mode_select_first, mode_select_second, mode_select_third} = 3'h6;
    output_enable = 1'b1;
    position_reset_b = 1'b1;
    step_clock = 1'b0;
    rotation_direction = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    tick(5);
    rst_b <= 1'b1;
    tick(WAKE + 10);
    t_regs();
    t_standby();
    t_modes();
    t_dir_reset();
    set_mode(3'h5);
    t_chop(1'b0, GATE_ONE_TWO, GATE_TWO_ONE);
    set_mode(3'h1);
    t_chop(1'b1, GATE_TWO_ONE, GATE_ONE_TWO);
    summarize();
  end
endmodule
